// file: qaf_chk.sv
`timescale 1ns/1ps
module qaf_chk #(
    parameter int SEG_W = 32
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic slot_strobe_i,
    input wire qaf_pkg::qaf_slot_control_header_type hdr_a_i,
    input wire qaf_pkg::qaf_slot_control_header_type hdr_b_i,
    input wire logic seg_valid_i,
    input wire logic seg_bus_sel_i,
    input wire logic [1:0] seg_pri_sel_i,
    input wire logic [5:0] seg_ready_o,
    input wire logic [1:0] set_busy_o,
    input wire logic [1:0] balance_count_pulse_o,
    input wire logic [1:0] seg_out_valid_o,
    input wire logic [SEG_W-1:0] seg_out_a_o,
    input wire logic [5:0] request_sender_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // ************
    // Claim outputs
    // ************
    property p_claim_pair;
        set_busy_o == balance_count_pulse_o;
    endproperty
    a_claim_pair: assert property (p_claim_pair)
        else $error("busy and balance pulses differ");
    property p_claim_valid;
        seg_out_valid_o == set_busy_o;
    endproperty
    a_claim_valid: assert property (p_claim_valid)
        else $error("valid differs from busy");
    property p_claim_a;
        set_busy_o[0] |-> $past(slot_strobe_i && ce_i &&
            !hdr_a_i.busy && !hdr_a_i.slot_kind_bit);
    endproperty
    a_claim_a: assert property (p_claim_a)
        else $error("bus A claim without empty slot");
    property p_claim_b;
        set_busy_o[1] |-> $past(slot_strobe_i && ce_i &&
            !hdr_b_i.busy && !hdr_b_i.slot_kind_bit);
    endproperty
    a_claim_b: assert property (p_claim_b)
        else $error("bus B claim without empty slot");
    property p_quiet;
        !slot_strobe_i |=> set_busy_o == 2'h0 && request_sender_o == 6'h00;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("slot pulse without strobe");
    property p_sender_once;
        |request_sender_o |=> (request_sender_o & $past(request_sender_o))
            == 6'h00;
    endproperty
    a_sender_once: assert property (p_sender_once)
        else $error("request pulse repeated");
    // Stale data would be mistaken for a new segment downstream
    property p_data_held;
        !seg_out_valid_o[0] && !$past(rst_i) |-> $stable(seg_out_a_o);
    endproperty
    a_data_held: assert property (p_data_held)
        else $error("bus A data changed unclaimed");
    property p_ready_fall;
        $fell(seg_ready_o[3]) |-> $past(seg_valid_i && seg_bus_sel_i &&
            seg_pri_sel_i == 2'h0);
    endproperty
    a_ready_fall: assert property (p_ready_fall)
        else $error("ready fell without push");
    c_claim_a: cover property (set_busy_o[0]);
    c_claim_b: cover property (set_busy_o[1]);
    c_sender: cover property (|request_sender_o);
endmodule

bind qaf_top qaf_chk #(.SEG_W(SEG_W)) u_chk (
    .clock_i, .rst_i, .ce_i, .slot_strobe_i, .hdr_a_i, .hdr_b_i,
    .seg_valid_i, .seg_bus_sel_i, .seg_pri_sel_i, .seg_ready_o,
    .set_busy_o, .balance_count_pulse_o, .seg_out_valid_o, .seg_out_a_o,
    .request_sender_o
);

// file: qaf_nodes.sv
`timescale 1ns/1ps
module qaf_nodes (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire qaf_pkg::qaf_slot_control_header_type hdr_a_i,
    input wire qaf_pkg::qaf_slot_control_header_type hdr_b_i,
    input wire logic [1:0] bal_i,
    output logic slot_strobe_o,
    output qaf_pkg::qaf_slot_control_header_type hdr_a_o,
    output qaf_pkg::qaf_slot_control_header_type hdr_b_o,
    output logic [1:0] bal_o
);
    // ************
    // Slot source of the other nodes
    // ************
    // Headers toggle between slots so none can pass as valid there
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            slot_strobe_o <= 1'b0;
            hdr_a_o <= '0;
            hdr_b_o <= '0;
            bal_o <= 2'h0;
        end else if (go_i) begin
            slot_strobe_o <= 1'b1;
            hdr_a_o <= hdr_a_i;
            hdr_b_o <= hdr_b_i;
            bal_o <= bal_i;
        end else begin
            slot_strobe_o <= 1'b0;
            hdr_a_o <= ~hdr_a_o;
            hdr_b_o <= ~hdr_b_o;
            bal_o <= ~bal_o;
        end
    end
endmodule

// file: qaf_pkg.sv
// Notes on behaviour
// [R1] Six access machines: two buses times three priority levels.
// [R2] Level 2 is the highest priority, level 0 the lowest.
// [R3] Machines on one bus share their local request indications.
// [R4] Each machine owns one pending-request and one countdown counter.
// [R5] One segment per machine; later ones wait in order-keeping local queue.
// [R6] Incoming segment goes to the machine chosen by bus and priority select.
// [R7] Bus counters read busy and kind bits here, request field opposite.
// [R8] Access need is signalled by the request sender on the opposite bus.
// [R9] Balancing activity on a bus alters that bus's counters.
// [R10] Idle: opposite requests at or above this level raise pending.
// [R11] Idle: higher sibling local request raises pending, saturating.
// [R12] Idle: empty queued-arbitrated slot lowers pending, not below zero.
// [R13] Idle machine given a segment to queue enters countdown.
// [R14] Countdown: empty slot with zero countdown is claimed; back to idle.
// [R15] Countdown: higher opposite or sibling requests raise countdown.
// [R16] Countdown: equal-level opposite requests raise pending only.
// [R17] Countdown: empty slot with countdown above zero lowers countdown.
// [R18] Balance reset raises countdown in countdown state, pending in idle.
// [R19] Empty queued-arbitrated means busy and kind bits both zero on arrival.
// [R20] Leaving idle: tell siblings, pending to countdown, clear, request.
// [R21] Claim: set busy, pulse balance count, start writing the segment.
// [R22] Several zero countdowns on one slot: only highest priority writes.
// [R23] Counter maximum is a parameter; every increment saturates there.
// [R24] All counter updates of one slot apply together, once per slot.
package qaf_pkg;

    // ****************************************
    // Slot header and machine states
    // ****************************************
    typedef struct packed {
        logic busy;
        logic slot_kind_bit;
        logic [2:0] request;
    } qaf_slot_control_header_type;

    typedef enum logic {
        idle_state,
        countdown_state
    } qaf_state_type;

    localparam int NUM_BUS = 2;
    localparam int NUM_PRI = 3;
    localparam int NUM_FSM = 6;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] COUNT_BASE_OFFSET = 8'h10;
    localparam logic [7:0] COUNT_LAST_OFFSET = 8'h24;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int STATUS_QUEUED_POS = 8;
    localparam int COUNT_CD_POS = 16;
    localparam logic CTRL_ENABLE_RESET = 1'b1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: qaf_top.sv
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module qaf_top #(
    parameter int CNT_W = 8,
    parameter int CNT_MAX = 255,
    parameter int SEG_W = 32,
    parameter int QDEPTH = 4
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Slot boundary, one pulse per slot time
    input wire logic slot_strobe_i,
    input wire qaf_pkg::qaf_slot_control_header_type hdr_a_i,
    input wire qaf_pkg::qaf_slot_control_header_type hdr_b_i,
    input wire logic [1:0] balance_reset_pulse_i,
    // Segment intake
    input wire logic seg_valid_i,
    input wire logic seg_bus_sel_i,
    input wire logic [1:0] seg_pri_sel_i,
    input wire logic [SEG_W-1:0] seg_data_i,
    output logic [5:0] seg_ready_o,
    // Per-bus claim outputs and per-machine request pulses
    output logic [1:0] set_busy_o,
    output logic [1:0] balance_count_pulse_o,
    output logic [1:0] seg_out_valid_o,
    output logic [SEG_W-1:0] seg_out_a_o,
    output logic [SEG_W-1:0] seg_out_b_o,
    output logic [5:0] request_sender_o,
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    input wire logic [7:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i
);

    // ****************************************
    // Machine storage
    // ****************************************
    qaf_pkg::qaf_state_type state [qaf_pkg::NUM_FSM];
    logic [CNT_W-1:0] pending_request_count [qaf_pkg::NUM_FSM]; // R4
    logic [CNT_W-1:0] countdown_count [qaf_pkg::NUM_FSM]; // R4
    logic [SEG_W-1:0] held_seg [qaf_pkg::NUM_FSM];
    logic [SEG_W-1:0] fifo_mem [qaf_pkg::NUM_FSM][QDEPTH];
    logic [$clog2(QDEPTH+1)-1:0] fifo_cnt [qaf_pkg::NUM_FSM];
    logic [$clog2(QDEPTH)-1:0] fifo_rd [qaf_pkg::NUM_FSM];
    logic [$clog2(QDEPTH)-1:0] fifo_wr [qaf_pkg::NUM_FSM];
    logic enable;
    qaf_pkg::qaf_state_type next_state [qaf_pkg::NUM_FSM];
    logic [CNT_W-1:0] next_pending [qaf_pkg::NUM_FSM];
    logic [CNT_W-1:0] next_countdown [qaf_pkg::NUM_FSM];
    logic [5:0] may_claim;
    logic [5:0] claim;
    logic [5:0] push;
    logic [5:0] pop;
    logic [1:0] empty_qa;
    logic slot_go;

    // Saturating net update, bounded to 0..CNT_MAX
    function automatic logic [CNT_W-1:0] sat_upd(input logic [CNT_W-1:0] v,
            input int inc, input int dec);
        int t;
        t = int'(v) + inc - dec;
        if (t > CNT_MAX) begin
            t = CNT_MAX; // R23
        end
        if (t < 0) begin
            t = 0;
        end
        return t[CNT_W-1:0];
    endfunction

    assign slot_go = ce_i && slot_strobe_i && enable; // R24
    assign empty_qa[0] = !hdr_a_i.busy && !hdr_a_i.slot_kind_bit; // R19 R7
    assign empty_qa[1] = !hdr_b_i.busy && !hdr_b_i.slot_kind_bit; // R19 R7

    // ****************************************
    // Segment intake and local queues
    // ****************************************
    always_comb begin
        for (int m = 0; m < qaf_pkg::NUM_FSM; m++) begin
            push[m] = ce_i && seg_valid_i && seg_ready_o[m] // R6
                && (int'(seg_bus_sel_i) * qaf_pkg::NUM_PRI
                + int'(seg_pri_sel_i) == m);
            pop[m] = slot_go && state[m] == qaf_pkg::idle_state
                && fifo_cnt[m] != '0; // R13 R20
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int m = 0; m < qaf_pkg::NUM_FSM; m++) begin
                fifo_cnt[m] <= '0;
                fifo_rd[m] <= '0;
                fifo_wr[m] <= '0;
            end
            seg_ready_o <= '1;
        end else if (ce_i) begin
            for (int m = 0; m < qaf_pkg::NUM_FSM; m++) begin
                // R5 arrival order kept by the ring
                if (push[m]) begin
                    fifo_mem[m][fifo_wr[m]] <= seg_data_i;
                    fifo_wr[m] <= fifo_wr[m] + 1'b1;
                end
                if (pop[m]) begin
                    held_seg[m] <= fifo_mem[m][fifo_rd[m]]; // R5
                    fifo_rd[m] <= fifo_rd[m] + 1'b1;
                end
                fifo_cnt[m] <= fifo_cnt[m] + push[m] - pop[m];
                // Ready from flop: only a push can fill it this cycle
                seg_ready_o[m] <= !(int'(fifo_cnt[m]) + int'(push[m])
                    - int'(pop[m]) >= QDEPTH);
            end
        end
    end

    // ****************************************
    // Access machine next-state logic
    // ****************************************
    always_comb begin
        int b;
        int p;
        int req_ge;
        int req_gt;
        int req_eq;
        int sib_gt;
        logic [2:0] opp;
        b = 0;
        p = 0;
        req_ge = 0;
        req_gt = 0;
        req_eq = 0;
        sib_gt = 0;
        opp = '0;
        for (int m = 0; m < qaf_pkg::NUM_FSM; m++) begin
            b = m / qaf_pkg::NUM_PRI; // R1
            p = m % qaf_pkg::NUM_PRI;
            opp = (b == 0) ? hdr_b_i.request : hdr_a_i.request; // R7 R8
            req_ge = 0;
            req_gt = 0;
            req_eq = 0;
            sib_gt = 0;
            for (int j = 0; j < qaf_pkg::NUM_PRI; j++) begin
                // R2 higher index is higher priority
                if (j >= p && opp[j]) begin
                    req_ge++;
                end
                if (j > p && opp[j]) begin
                    req_gt++;
                end
                if (j == p && opp[j]) begin
                    req_eq++;
                end
                if (j > p && pop[b*qaf_pkg::NUM_PRI+j]) begin
                    sib_gt++; // R3
                end
            end
            may_claim[m] = state[m] == qaf_pkg::countdown_state
                && empty_qa[b] && countdown_count[m] == '0;
            next_state[m] = state[m];
            next_pending[m] = pending_request_count[m];
            next_countdown[m] = countdown_count[m];
            if (slot_go) begin
                case (state[m])
                    qaf_pkg::idle_state: begin
                        // R10 R11 R12 R18 R9
                        next_pending[m] = sat_upd(pending_request_count[m],
                            req_ge + sib_gt + int'(balance_reset_pulse_i[b]),
                            int'(empty_qa[b]));
                        if (fifo_cnt[m] != '0) begin
                            next_countdown[m] = next_pending[m]; // R20
                            next_pending[m] = '0; // R20
                            next_state[m] = qaf_pkg::countdown_state; // R13
                        end
                    end
                    qaf_pkg::countdown_state: begin
                        // R15 R17 R18 R9
                        next_countdown[m] = sat_upd(countdown_count[m],
                            req_gt + sib_gt + int'(balance_reset_pulse_i[b]),
                            int'(empty_qa[b] && countdown_count[m] != '0));
                        next_pending[m] = sat_upd(pending_request_count[m],
                            req_eq, 0); // R16
                    end
                    default: begin
                        next_state[m] = qaf_pkg::idle_state;
                    end
                endcase
            end
        end
        // R22 lower machines on the same bus yield to a higher claimant
        for (int bb = 0; bb < qaf_pkg::NUM_BUS; bb++) begin
            for (int pp = 0; pp < qaf_pkg::NUM_PRI; pp++) begin
                claim[bb*qaf_pkg::NUM_PRI+pp] = slot_go
                    && may_claim[bb*qaf_pkg::NUM_PRI+pp];
                for (int q = pp + 1; q < qaf_pkg::NUM_PRI; q++) begin
                    if (may_claim[bb*qaf_pkg::NUM_PRI+q]) begin
                        claim[bb*qaf_pkg::NUM_PRI+pp] = 1'b0; // R22
                    end
                end
            end
        end
        for (int m = 0; m < qaf_pkg::NUM_FSM; m++) begin
            if (claim[m]) begin
                next_state[m] = qaf_pkg::idle_state; // R14
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int m = 0; m < qaf_pkg::NUM_FSM; m++) begin
                state[m] <= qaf_pkg::idle_state;
                pending_request_count[m] <= '0;
                countdown_count[m] <= '0;
            end
        end else if (ce_i) begin
            for (int m = 0; m < qaf_pkg::NUM_FSM; m++) begin
                state[m] <= next_state[m]; // R24
                pending_request_count[m] <= next_pending[m];
                countdown_count[m] <= next_countdown[m];
            end
        end
    end

    // ****************************************
    // Claim and request outputs
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            set_busy_o <= '0;
            balance_count_pulse_o <= '0;
            seg_out_valid_o <= '0;
            seg_out_a_o <= '0;
            seg_out_b_o <= '0;
            request_sender_o <= '0;
        end else if (ce_i) begin
            request_sender_o <= pop; // R20 R8
            set_busy_o <= '0;
            balance_count_pulse_o <= '0;
            seg_out_valid_o <= '0;
            for (int m = 0; m < qaf_pkg::NUM_FSM; m++) begin
                if (claim[m]) begin
                    // R21 busy bit, balance count and segment together
                    set_busy_o[m/qaf_pkg::NUM_PRI] <= 1'b1;
                    balance_count_pulse_o[m/qaf_pkg::NUM_PRI] <= 1'b1;
                    seg_out_valid_o[m/qaf_pkg::NUM_PRI] <= 1'b1;
                    if (m < qaf_pkg::NUM_PRI) begin
                        seg_out_a_o <= held_seg[m];
                    end else begin
                        seg_out_b_o <= held_seg[m];
                    end
                end
            end
        end
    end

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_awready_o <= 1'b1;
            s_wready_o <= 1'b1;
            s_bvalid_o <= 1'b0;
            s_bresp_o <= qaf_pkg::RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            enable <= qaf_pkg::CTRL_ENABLE_RESET;
        end else if (ce_i) begin
            if (s_awvalid_i && s_awready_o) begin
                aw_addr <= s_awaddr_i;
                aw_held <= 1'b1;
                s_awready_o <= 1'b0;
            end
            if (s_wvalid_i && s_wready_o) begin
                w_data <= s_wdata_i;
                w_strb <= s_wstrb_i;
                w_held <= 1'b1;
                s_wready_o <= 1'b0;
            end
            if (aw_held && w_held && !s_bvalid_o) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_bvalid_o <= 1'b1;
                s_bresp_o <= qaf_pkg::RESP_OKAY;
                if (aw_addr[7:2] == qaf_pkg::CTRL_OFFSET[7:2]) begin
                    if (w_strb[0]) begin
                        enable <= w_data[qaf_pkg::CTRL_ENABLE_BIT];
                    end
                end else if (!(aw_addr[7:2] == qaf_pkg::STATUS_OFFSET[7:2]
                        || (aw_addr >= qaf_pkg::COUNT_BASE_OFFSET
                        && aw_addr <= qaf_pkg::COUNT_LAST_OFFSET))) begin
                    s_bresp_o <= qaf_pkg::RESP_SLVERR;
                end
            end
            if (s_bvalid_o && s_bready_i) begin
                s_bvalid_o <= 1'b0;
                s_awready_o <= 1'b1;
                s_wready_o <= 1'b1;
            end
        end
    end

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_arready_o <= 1'b1;
            s_rvalid_o <= 1'b0;
            s_rdata_o <= '0;
            s_rresp_o <= qaf_pkg::RESP_OKAY;
        end else if (ce_i) begin
            if (s_arvalid_i && s_arready_o) begin
                s_arready_o <= 1'b0;
                s_rvalid_o <= 1'b1;
                s_rdata_o <= '0;
                s_rresp_o <= qaf_pkg::RESP_OKAY;
                if (s_araddr_i[7:2] == qaf_pkg::CTRL_OFFSET[7:2]) begin
                    s_rdata_o[qaf_pkg::CTRL_ENABLE_BIT] <= enable;
                end else if (s_araddr_i[7:2]
                        == qaf_pkg::STATUS_OFFSET[7:2]) begin
                    for (int m = 0; m < qaf_pkg::NUM_FSM; m++) begin
                        s_rdata_o[m] <= state[m]
                            == qaf_pkg::countdown_state;
                        s_rdata_o[qaf_pkg::STATUS_QUEUED_POS+m]
                            <= fifo_cnt[m] != '0;
                    end
                end else if (s_araddr_i >= qaf_pkg::COUNT_BASE_OFFSET
                        && s_araddr_i <= qaf_pkg::COUNT_LAST_OFFSET) begin
                    for (int m = 0; m < qaf_pkg::NUM_FSM; m++) begin
                        if (s_araddr_i[7:2] == 6'(m + int'(
                                qaf_pkg::COUNT_BASE_OFFSET[7:2]))) begin
                            s_rdata_o[CNT_W-1:0]
                                <= pending_request_count[m];
                            s_rdata_o[qaf_pkg::COUNT_CD_POS+:CNT_W]
                                <= countdown_count[m];
                        end
                    end
                end else begin
                    s_rresp_o <= qaf_pkg::RESP_SLVERR;
                end
            end
            if (s_rvalid_o && s_rready_i) begin
                s_rvalid_o <= 1'b0;
                s_arready_o <= 1'b1;
            end
        end
    end

endmodule

// file: qaf_top_tb.sv
`timescale 1ns/1ps
module qaf_top_tb;
    // ************
    // Signals
    // ************
    localparam logic [4:0] H_BUSY = 5'h10;
    localparam logic [4:0] H_R7 = 5'h17;
    localparam logic [4:0] H_R4 = 5'h14;
    localparam logic [4:0] H_EMPTY = 5'h00;
    localparam logic [4:0] H_KIND = 5'h08;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic go = 1'b0;
    logic [1:0] nbal = 2'h0;
    qaf_pkg::qaf_slot_control_header_type na = '0;
    qaf_pkg::qaf_slot_control_header_type nb = '0;
    qaf_pkg::qaf_slot_control_header_type hdr_a_i;
    qaf_pkg::qaf_slot_control_header_type hdr_b_i;
    logic slot_strobe_i;
    logic [1:0] balance_reset_pulse_i;
    logic seg_valid_i = 1'b0;
    logic seg_bus_sel_i = 1'b0;
    logic [1:0] seg_pri_sel_i = 2'h0;
    logic [31:0] seg_data_i = 32'h0;
    logic [7:0] s_awaddr_i = 8'h00;
    logic [7:0] s_araddr_i = 8'h00;
    logic [31:0] s_wdata_i = 32'h0;
    logic s_awvalid_i = 1'b0;
    logic s_wvalid_i = 1'b0;
    logic s_bready_i = 1'b0;
    logic s_arvalid_i = 1'b0;
    logic s_rready_i = 1'b0;
    logic [5:0] seg_ready_o, request_sender_o, grs;
    logic [1:0] set_busy_o, balance_count_pulse_o, seg_out_valid_o;
    logic [1:0] gbusy, gbcp, gval, s_bresp_o, s_rresp_o, rr;
    logic [31:0] seg_out_a_o, seg_out_b_o, s_rdata_o, ga, gb, rd;
    logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
    int fails = 0;
    int num_checks = 0;
    int n;
    int k;

    qaf_top #(.CNT_MAX(3)) u_dut (
        .clock_i, .rst_i, .ce_i(1'b1), .slot_strobe_i, .hdr_a_i, .hdr_b_i,
        .balance_reset_pulse_i, .seg_valid_i, .seg_bus_sel_i,
        .seg_pri_sel_i, .seg_data_i, .seg_ready_o, .set_busy_o,
        .balance_count_pulse_o, .seg_out_valid_o, .seg_out_a_o,
        .seg_out_b_o, .request_sender_o, .s_awaddr_i, .s_awvalid_i,
        .s_awready_o, .s_wdata_i, .s_wstrb_i(4'hf), .s_wvalid_i,
        .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i,
        .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o,
        .s_rready_i
    );
    qaf_nodes u_nodes (
        .clock_i, .rst_i, .go_i(go), .hdr_a_i(na), .hdr_b_i(nb),
        .bal_i(nbal), .slot_strobe_o(slot_strobe_i), .hdr_a_o(hdr_a_i),
        .hdr_b_o(hdr_b_i), .bal_o(balance_reset_pulse_i)
    );

    initial begin
        forever #25 clock_i = ~clock_i;
    end

    // ************
    // Tasks
    // ************
    task conclude;
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tmo;
        if (n > 200) begin
            chk("wait", 32'h0, 32'h1);
            conclude();
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        s_awaddr_i <= a;
        s_wdata_i <= d;
        s_awvalid_i <= 1'b1;
        s_wvalid_i <= 1'b1;
        s_bready_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
            if (s_awready_o) s_awvalid_i <= 1'b0;
            if (s_wready_o) s_wvalid_i <= 1'b0;
            tmo();
        end while (s_bvalid_o !== 1'b1);
        rr = s_bresp_o;
        s_bready_i <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge clock_i);
        s_araddr_i <= a;
        s_arvalid_i <= 1'b1;
        s_rready_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
            if (s_arready_o) s_arvalid_i <= 1'b0;
            tmo();
        end while (s_rvalid_o !== 1'b1);
        rd = s_rdata_o;
        rr = s_rresp_o;
        s_rready_i <= 1'b0;
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        rd_reg(a);
        chk(nm, e, rd);
    endtask
    task push(input logic b, input logic [1:0] p, input logic [31:0] d);
        @(posedge clock_i);
        seg_valid_i <= 1'b1;
        seg_bus_sel_i <= b;
        seg_pri_sel_i <= p;
        seg_data_i <= d;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
            tmo();
        end while (seg_ready_o[b * 3 + p] !== 1'b1);
        seg_valid_i <= 1'b0;
    endtask
    // Outputs are read one cycle after the strobe edge
    task slot(input logic [4:0] a, input logic [4:0] b, input logic [1:0] c);
        @(posedge clock_i);
        go <= 1'b1;
        na <= a;
        nb <= b;
        nbal <= c;
        @(posedge clock_i);
        go <= 1'b0;
        @(posedge clock_i);
        #1;
        gbusy = set_busy_o;
        gbcp = balance_count_pulse_o;
        gval = seg_out_valid_o;
        grs = request_sender_o;
        ga = seg_out_a_o;
        gb = seg_out_b_o;
    endtask

    // ************
    // Scenarios
    // ************
    initial begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        slot(H_BUSY, H_R7, 2'h0);
        rchk("count0", 8'h10, 32'h3);
        slot(H_BUSY, H_R7, 2'h0);
        rchk("count1", 8'h14, 32'h3);
        repeat (2) slot(H_EMPTY, H_BUSY, 2'h0);
        rchk("count2", 8'h18, 32'h0);
        rchk("count0", 8'h10, 32'h1);
        slot(H_KIND, H_BUSY, 2'h1);
        rchk("count0", 8'h10, 32'h2);
        push(1'b0, 2'h2, 32'ha2);
        slot(H_BUSY, H_BUSY, 2'h0);
        chk("sender", 32'h4, 32'(grs));
        rchk("count2", 8'h18, 32'h10000);
        rchk("count0", 8'h10, 32'h3);
        slot(H_BUSY, H_R4, 2'h0);
        rchk("count2", 8'h18, 32'h10001);
        slot(H_EMPTY, H_BUSY, 2'h0);
        rchk("count2", 8'h18, 32'h1);
        slot(H_EMPTY, H_BUSY, 2'h0);
        chk("busy", 32'h1, 32'(gbusy));
        chk("bal_count", 32'h1, 32'(gbcp));
        chk("seg_a", 32'ha2, ga);
        push(1'b0, 2'h0, 32'ha0);
        slot(H_BUSY, H_BUSY, 2'h0);
        push(1'b0, 2'h1, 32'ha1);
        slot(H_BUSY, H_BUSY, 2'h0);
        rchk("count0", 8'h10, 32'h20000);
        repeat (2) slot(H_BUSY, H_R4, 2'h0);
        rchk("count0", 8'h10, 32'h30000);
        rchk("count1", 8'h14, 32'h30000);
        repeat (4) slot(H_EMPTY, H_BUSY, 2'h0);
        chk("seg_a", 32'ha1, ga);
        slot(H_EMPTY, H_BUSY, 2'h0);
        chk("seg_a", 32'ha0, ga);
        wr(qaf_pkg::CTRL_OFFSET, 32'h0);
        chk("bresp", 32'(qaf_pkg::RESP_OKAY), 32'(rr));
        rchk("ctrl", qaf_pkg::CTRL_OFFSET, 32'h0);
        slot(H_BUSY, H_R7, 2'h1);
        rchk("count0", 8'h10, 32'h0);
        wr(qaf_pkg::CTRL_OFFSET, 32'h1);
        rd_reg(8'h40);
        chk("rresp", 32'(qaf_pkg::RESP_SLVERR), 32'(rr));
        chk("rdata", 32'h0, rd);
        rchk("status", qaf_pkg::STATUS_OFFSET, 32'h0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) push(1'b1, 2'h0, 32'hb0 + i);
        #1;
        chk("ready", 32'h37, 32'(seg_ready_o));
        k = 0;
        repeat (8) begin
            slot(H_BUSY, H_EMPTY, 2'h0);
            if (gval[1] === 1'b1) begin
                chk("seg_b", 32'hb0 + k, gb);
                k++;
            end
        end
        chk("claims_b", 32'h4, 32'(k));
        conclude();
    end
endmodule
